// ===== rtl/flash_pin_interface.sv
// pin-level shifter of a serial flash: chip select framing, pause, write protect, lanes
// assumes a command layer beside it chooses lane mode and direction per byte
module flash_pin_interface (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic [3:0] data_lines_in,
    output logic [3:0] data_lines_out,
    output logic [3:0] data_lines_oe,
    input wire logic quad_pin_enable,
    input wire flash_pin_pkg::lane_mode_e lane_mode,
    input wire logic drive_out,
    input wire logic [7:0] tx_byte,
    output logic tx_take,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic frame_open,
    output logic active_power,
    input wire logic write_busy,
    output logic standby,
    input wire logic [2:0] protected_area_bits,
    input wire logic target_in_protected,
    output logic modify_blocked
);

    typedef struct packed {
        logic sck_prev;
        logic armed;
        logic [1:0] settle;
        logic [7:0] rx_sh;
        logic [3:0] rx_cnt;
        logic [7:0] rx_byte;
        logic rx_valid;
        logic [7:0] tx_sh;
        logic [3:0] tx_cnt;
        logic tx_take;
        logic [3:0] out;
        logic [3:0] oe;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic sck_s;
    logic cs_n_s;
    logic [3:0] io_s;
    logic rise;
    logic fall;
    logic selected;
    logic hold_active;
    logic quad_ok;
    logic settled;
    flash_pin_pkg::lane_mode_e mode;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] lanes(input flash_pin_pkg::lane_mode_e m);
        unique case (m)
            flash_pin_pkg::lane_single: lanes = 4'h1;
            flash_pin_pkg::lane_dual: lanes = 4'h2;
            flash_pin_pkg::lane_quad: lanes = 4'h4;
            default: lanes = 4'h1;
        endcase
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] io,
                                            input flash_pin_pkg::lane_mode_e m);
        unique case (m)
            flash_pin_pkg::lane_dual: shift_in = {sh[5:0], io[1:0]};
            flash_pin_pkg::lane_quad: shift_in = {sh[3:0], io[3:0]};
            default: shift_in = {sh[6:0], io[0]};
        endcase
    endfunction

    function automatic logic [3:0] lane_bits(input logic [7:0] b,
                                             input flash_pin_pkg::lane_mode_e m);
        unique case (m)
            flash_pin_pkg::lane_dual: lane_bits = {2'b00, b[7:6]};
            flash_pin_pkg::lane_quad: lane_bits = b[7:4];
            default: lane_bits = {2'b00, b[7], 1'b0};
        endcase
    endfunction

    // output enables per mode; line one is an input while not driving
    function automatic logic [3:0] lane_oe(input flash_pin_pkg::lane_mode_e m);
        unique case (m)
            flash_pin_pkg::lane_dual: lane_oe = 4'b0011;
            flash_pin_pkg::lane_quad: lane_oe = 4'b1111;
            default: lane_oe = 4'b0010;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    pin_sync #(
        .width(6),
        .rst_value({flash_pin_pkg::select_idle, flash_pin_pkg::clock_idle, 4'h0})
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .pins({chip_select_n, serial_clock, data_lines_in}),
        .levels({cs_n_s, sck_s, io_s})
    );

    // ----------------------------------------------------------------
    // decode of pins and modes
    // ----------------------------------------------------------------
    // synced edges: serial clock limited to about a sixth of clock
    assign rise = sck_s && !s_q.sck_prev;
    assign fall = !sck_s && s_q.sck_prev;
    assign quad_ok = quad_pin_enable;
    // quad request without the pin enable falls back to one lane
    assign mode = (lane_mode == flash_pin_pkg::lane_quad && !quad_ok) ?
                  flash_pin_pkg::lane_single : lane_mode;
    assign selected = !cs_n_s && s_q.armed;
    assign hold_active = !cs_n_s && !io_s[3] && !quad_ok;

    // ----------------------------------------------------------------
    // settling after reset
    // ----------------------------------------------------------------
    // the synchroniser shows its reset level first; arming on it would
    // treat a select held low through reset as a real falling edge
    assign settled = s_q.settle == flash_pin_pkg::settle_done;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.sck_prev = sck_s;
        s_d.rx_valid = 1'b0;
        s_d.tx_take = 1'b0;
        if (!settled) begin
            s_d.settle = s_q.settle + 2'h1;
        end
        if (cs_n_s) begin
            // a partial byte is dropped when select rises
            s_d.armed = s_q.armed || settled;
            s_d.rx_cnt = flash_pin_pkg::bit_count_rst;
            s_d.tx_cnt = flash_pin_pkg::bit_count_rst;
            s_d.oe = flash_pin_pkg::lines_rst;
        end else if (!s_q.armed) begin
            // select held low through reset: wait for it to rise
            s_d.oe = flash_pin_pkg::lines_rst;
        end else if (hold_active) begin
            // counters freeze, so the byte resumes where it stopped
            s_d.oe = flash_pin_pkg::lines_rst;
        end else begin
            if (rise) begin
                s_d.rx_sh = shift_in(s_q.rx_sh, io_s, mode);
                s_d.rx_cnt = s_q.rx_cnt + lanes(mode);
                if (s_d.rx_cnt == flash_pin_pkg::full_byte) begin
                    s_d.rx_cnt = flash_pin_pkg::bit_count_rst;
                    s_d.rx_byte = s_d.rx_sh;
                    s_d.rx_valid = !drive_out;
                end
            end
            // mode 3 opens with a fall, which loads the first bits of tx_byte only if drive_out is already set
            if (!drive_out) begin
                s_d.oe = flash_pin_pkg::lines_rst;
                s_d.tx_cnt = flash_pin_pkg::bit_count_rst;
            end else if (fall) begin
                // one byte is fetched per eight bits, so tx_byte must be valid by the first fall of each byte
                if (s_q.tx_cnt == flash_pin_pkg::bit_count_rst) begin
                    s_d.out = lane_bits(tx_byte, mode);
                    s_d.tx_sh = tx_byte << lanes(mode);
                    s_d.tx_take = 1'b1;
                end else begin
                    s_d.out = lane_bits(s_q.tx_sh, mode);
                    s_d.tx_sh = s_q.tx_sh << lanes(mode);
                end
                s_d.tx_cnt = s_q.tx_cnt + lanes(mode);
                if (s_d.tx_cnt == flash_pin_pkg::full_byte) begin
                    s_d.tx_cnt = flash_pin_pkg::bit_count_rst;
                end
                s_d.oe = lane_oe(mode);
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{sck_prev: flash_pin_pkg::clock_idle,
                     armed: 1'b0,
                     settle: flash_pin_pkg::settle_rst,
                     rx_sh: flash_pin_pkg::byte_rst,
                     rx_cnt: flash_pin_pkg::bit_count_rst,
                     rx_byte: flash_pin_pkg::byte_rst,
                     rx_valid: 1'b0,
                     tx_sh: flash_pin_pkg::byte_rst,
                     tx_cnt: flash_pin_pkg::bit_count_rst,
                     tx_take: 1'b0,
                     out: flash_pin_pkg::lines_rst,
                     oe: flash_pin_pkg::lines_rst};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign data_lines_out = s_q.out;
    assign data_lines_oe = s_q.oe;
    assign tx_take = s_q.tx_take;
    assign rx_byte = s_q.rx_byte;
    assign rx_valid = s_q.rx_valid;
    // status levels are combinational from synced pins
    assign frame_open = selected;
    assign active_power = !cs_n_s || write_busy;
    assign standby = cs_n_s && !write_busy;
    // protection needs the pin function, so quad_pin_enable disables it whatever the lane mode
    assign modify_blocked = !io_s[2] && !quad_ok && (protected_area_bits != 3'h0)
                            && target_in_protected;

endmodule // flash_pin_interface

// ===== pkg/flash_pin_pkg.sv
// constants and types shared by the serial flash pin interface
// assumes one system clock; every pin reaches logic through two flip-flops
//
// Summary of operation
// - in single-line output the bit on data line one changes on each falling serial clock edge.
// - data line one turns into an input during dual or quad input phases and quad page program.
// - command, address and program data bits are taken from data line zero on rising edges.
// - data line zero is driven as an output while dual or quad read data is returned.
// - chip select high deselects the device and floats its outputs; low means active power.
// - standby is entered once deselected and no program, erase or register write is busy.
// - pause low with chip select low floats the output and ignores data and clock edges.
// - write-protect low blocks program and erase of the region named by the protected area bits.
// - in quad transfers the pause and write-protect pins are driven as data lines three and two.
// - with the four-lane enable set, protect and pause pins act only as data lines two and three.
// - clock modes 0 and 3 are both served: sample on rising, shift out on falling edges.
// - every transfer is organised in whole bytes of eight bits.
package flash_pin_pkg;

    // ----------------------------------------------------------------
    // lane modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        lane_single,
        lane_dual,
        lane_quad
    } lane_mode_e;

    // ----------------------------------------------------------------
    // sizes and reset values
    // ----------------------------------------------------------------
    localparam int unsigned byte_bits = 8;
    localparam int unsigned sync_stages = 2;
    localparam logic [3:0] bit_count_rst = 4'h0;
    localparam logic [7:0] byte_rst = 8'h00;
    localparam logic [3:0] lines_rst = 4'h0;
    localparam logic select_idle = 1'b1;
    localparam logic clock_idle = 1'b0;
    localparam logic [3:0] full_byte = 4'h8;
    localparam logic [1:0] settle_rst = 2'h0;
    localparam logic [1:0] settle_done = 2'(sync_stages);

endpackage

// ===== rtl/pin_sync.sv
// two-stage synchroniser for a group of pin levels
// assumes the levels are slow against the clock; a pulse shorter than one cycle can be lost
module pin_sync #(
    parameter int unsigned width = 1,
    parameter logic [width-1:0] rst_value = '0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [width-1:0] pins,
    output logic [width-1:0] levels
);

    logic [width-1:0] meta_q;
    logic [width-1:0] levels_q;

    // ----------------------------------------------------------------
    // first stage read only by the second
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= rst_value;
            levels_q <= rst_value;
        end else begin
            meta_q <= pins;
            levels_q <= meta_q;
        end
    end

    assign levels = levels_q;

endmodule // pin_sync

// ===== bench/flash_pin_asserts.sv
// assertions on the ports of the flash pin interface
// assumes a bind from the bench top file and one clock domain
module flash_pin_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic [3:0] data_lines_in,
    input wire logic [3:0] data_lines_oe,
    input wire logic quad_pin_enable,
    input wire flash_pin_pkg::lane_mode_e lane_mode,
    input wire logic drive_out,
    input wire logic rx_valid,
    input wire logic tx_take,
    input wire logic write_busy,
    input wire logic standby,
    input wire logic [2:0] protected_area_bits,
    input wire logic target_in_protected,
    input wire logic modify_blocked
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // repeat counts cover the two sync flops on pin inputs plus the output register on data_lines_oe
    desel_float_a: assert property (chip_select_n [*4] |-> data_lines_oe == 4'h0)
        else $error("lanes driven while deselected");
    standby_entry_a: assert property ((chip_select_n && !write_busy) [*3] |-> standby)
        else $error("no standby while idle");
    pause_float_a: assert property (
        (!data_lines_in[3] && !chip_select_n && !quad_pin_enable) [*4] |-> data_lines_oe == 4'h0)
        else $error("lanes driven while paused");
    protect_block_a: assert property (
        (!data_lines_in[2] && !quad_pin_enable && target_in_protected
        && |protected_area_bits) [*3] |-> modify_blocked) else $error("write not blocked");
    quad_unprotect_a: assert property (modify_blocked |-> !quad_pin_enable
        && target_in_protected && |protected_area_bits) else $error("blocked without cause");
    single_lane_a: assert property (drive_out && lane_mode == flash_pin_pkg::lane_single
        && |data_lines_oe |-> data_lines_oe == 4'h2) else $error("single output not on line one");
    quad_lane_a: assert property (drive_out && lane_mode == flash_pin_pkg::lane_quad
        && quad_pin_enable && |data_lines_oe |-> data_lines_oe == 4'hf) else $error("quad lanes");
    input_phase_a: assert property (!drive_out [*2] |-> data_lines_oe == 4'h0)
        else $error("lanes driven in input phase");
    byte_spacing_a: assert property (rx_valid |=> !rx_valid [*8])
        else $error("byte shorter than eight bits");
    cover property (rx_valid);
    cover property (tx_take);
    cover property (modify_blocked);
endmodule // flash_pin_asserts

// ===== bench/flash_host_model.sv
// host master model: makes serial clock and select, drives and samples lanes
// assumes the bench resolves each lane from the device's output enables
module flash_host_model (
    output logic sck,
    output logic cs_n,
    output logic [3:0] hd,
    input wire logic [3:0] lines
);
    timeunit 1ns;
    timeprecision 1ps;
    bit mode3;
    // select held low through reset, so the first frame must be refused
    initial begin
        {sck, cs_n, hd} = 6'h0f;
    end
    task automatic open_frame(input bit m3);
        mode3 = m3;
        sck = m3;
        #40 cs_n = 1'b0;
        #40;
    endtask
    task automatic close_frame();
        #40 sck = mode3;
        #40 cs_n = 1'b1;
        hd = 4'hf;
        #160;
    endtask
    // p names the group held behind a pause with one ignored clock pulse
    task automatic xfer(input logic [7:0] b, input int w, input int p, output logic [7:0] got);
        for (int i = 8; i > 0; i -= w) begin
            sck = 1'b0;
            if (i == p) begin
                hd[3] = 1'b0;
                #40 sck = 1'b1;
                #40 sck = 1'b0;
                #40;
            end
            hd = w == 4 ? b[i-1 -: 4] : w == 2 ? {2'b11, b[i-1 -: 2]}
                : {2'b11, ~hd[1], b[i-1]};
            #40 sck = 1'b1;
            got = w == 4 ? {got[3:0], lines} : w == 2 ? {got[5:0], lines[1:0]}
                : {got[6:0], lines[1]};
            #40;
        end
    endtask
endmodule // flash_host_model

// ===== bench/flash_pin_interface_test.sv
// self-checking bench for the flash pin interface against a host model
// assumes the package, design, host model and checker compile first
module flash_pin_interface_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic quad_pin_enable = 1'b0;
    logic drive_out = 1'b0;
    logic write_busy = 1'b0;
    logic target_in_protected = 1'b0;
    logic [2:0] protected_area_bits = 3'h0;
    logic [7:0] tx_byte = 8'h00;
    flash_pin_pkg::lane_mode_e lane_mode = flash_pin_pkg::lane_single;
    logic sck, cs_n, tx_take, rx_valid, frame_open, active_power, standby, modify_blocked;
    logic [3:0] hd, lines, dout, oe;
    logic [7:0] rx_byte, got, r;
    logic [7:0] exp_q[$];
    int errors = 0;
    int checks = 0;
    int takes = 0;
    always #4 clock = ~clock;
    assign lines = (oe & dout) | (~oe & hd);
    flash_host_model host_u (.sck(sck), .cs_n(cs_n), .hd(hd), .lines(lines));
    flash_pin_interface dut_u (.clock(clock), .rst_n(rst_n), .serial_clock(sck),
        .chip_select_n(cs_n), .data_lines_in(lines), .data_lines_out(dout), .data_lines_oe(oe),
        .quad_pin_enable(quad_pin_enable), .lane_mode(lane_mode), .drive_out(drive_out),
        .tx_byte(tx_byte), .tx_take(tx_take), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .frame_open(frame_open), .active_power(active_power), .write_busy(write_busy),
        .standby(standby), .protected_area_bits(protected_area_bits),
        .target_in_protected(target_in_protected), .modify_blocked(modify_blocked));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic setm(input flash_pin_pkg::lane_mode_e m, input logic q, input logic d,
        input logic [7:0] t);
        @(posedge clock);
        lane_mode <= m;
        quad_pin_enable <= q;
        drive_out <= d;
        tx_byte <= t;
        // host pins move half a cycle off the sampling edge
        @(negedge clock);
    endtask
    task automatic rx(input int w, input int p);
        r = 8'($urandom);
        exp_q.push_back(r);
        host_u.xfer(r, w, p, got);
    endtask
    always @(posedge clock) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0)
                check(8'h01, 8'h00);
            else
                check(rx_byte, exp_q.pop_front());
        end
        if (tx_take === 1'b1) begin
            takes++;
        end
    end
    initial begin
        #100000;
        errors++;
        give_verdict();
    end
    initial begin
        flash_pin_pkg::lane_mode_e lm;
        logic [7:0] t;
        void'($urandom(54718));
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        host_u.xfer(8'($urandom), 1, 0, got);
        check({7'h0, frame_open}, 8'h00);
        host_u.close_frame();
        $display("test arming done");
        // single, dual, then quad in clock mode 3; receive twice, then send
        for (int m = 0; m < 3; m++) begin
            lm = flash_pin_pkg::lane_mode_e'(m);
            t = 8'($urandom);
            setm(lm, m == 2, 1'b0, 8'h00);
            host_u.open_frame(m == 2);
            rx(1 << m, 0);
            rx(1 << m, 0);
            check({7'h0, frame_open}, 8'h01);
            setm(lm, m == 2, 1'b1, t);
            host_u.xfer(8'($urandom), 1 << m, 0, got);
            check(got, t);
            check(8'(takes), 8'(m + 1));
            check({4'h0, oe}, m == 0 ? 8'h02 : m == 1 ? 8'h03 : 8'h0f);
            setm(lm, m == 2, 1'b0, 8'h00);
            host_u.close_frame();
            $display("test lanes %0d done", m);
        end
        setm(flash_pin_pkg::lane_single, 1'b0, 1'b0, 8'h00);
        host_u.open_frame(1'b0);
        rx(1, 4);
        host_u.close_frame();
        check(8'(exp_q.size()), 8'h00);
        $display("test pause done");
        @(posedge clock);
        protected_area_bits <= 3'($urandom_range(7, 1));
        target_in_protected <= 1'b1;
        write_busy <= 1'b1;
        host_u.hd[2] <= 1'b0;
        repeat (4) @(posedge clock);
        #1 check({5'h0, active_power, modify_blocked, standby}, 8'h06);
        quad_pin_enable <= 1'b1;
        write_busy <= 1'b0;
        repeat (2) @(posedge clock);
        #1 check({5'h0, active_power, modify_blocked, standby}, 8'h01);
        $display("test protect done");
        give_verdict();
    end
endmodule // flash_pin_interface_test
bind flash_pin_interface flash_pin_asserts chk_u (.*);
